// ### logic/dffc_pkg.sv
// Purpose: shared constants of the dynamic fan floor control block
// Assumes: register indices map to byte address index*4 on the bus
// Notes: one word per register, data in bits 7:0
package dffc_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int IDX_W = 7;
  // ==========================================================
  // register indices
  localparam logic [IDX_W-1:0] IDX_OPPT_R1 = 7'h33;
  localparam logic [IDX_W-1:0] IDX_OPPT_LOC = 7'h34;
  localparam logic [IDX_W-1:0] IDX_OPPT_R2 = 7'h35;
  localparam logic [IDX_W-1:0] IDX_CTRL1 = 7'h36;
  localparam logic [IDX_W-1:0] IDX_CTRL2 = 7'h37;
  localparam logic [IDX_W-1:0] IDX_CFG = 7'h40;
  localparam logic [IDX_W-1:0] IDX_STAT = 7'h41;
  localparam logic [IDX_W-1:0] IDX_MASK = 7'h42;
  localparam logic [IDX_W-1:0] IDX_CORE_LIM = 7'h46;
  // ==========================================================
  // control register 1 fields
  localparam int C1_R2_MSB = 0;
  localparam int C1_GUARD = 1;
  localparam int C1_CAP_R1 = 2;
  localparam int C1_CAP_LOC = 3;
  localparam int C1_CAP_R2 = 4;
  localparam int C1_DYN_R1 = 5;
  localparam int C1_DYN_LOC = 6;
  localparam int C1_DYN_R2 = 7;
  // control register 2 fields
  localparam int C2_R1_LSB = 0;
  localparam int C2_LOC_LSB = 3;
  localparam int C2_R2_LSB = 6;
  // configuration, status and mask fields
  localparam int CFG_LOCK = 0;
  localparam int ST_CAPTURE = 0;
  localparam int ST_CORE_LOW = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPPT_RST = 8'h64;
  localparam logic [7:0] LIM_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // ==========================================================
  // adjustment waits, in monitoring cycles, for code 000
  localparam int CNT_W = 10;
  localparam logic [10:0] DEC_BASE = 11'h004;
  localparam logic [10:0] INC_BASE = 11'h008;
  localparam int NCH = 3;
endpackage : dffc_pkg

// ### logic/dffc_timer_if.sv
// Purpose: link between the control core and one interval timer
// Assumes: all signals on ref_clk
// Notes: dec_due and inc_due are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface dffc_timer_if;
  logic run;
  logic [2:0] code;
  logic tick;
  logic dec_due;
  logic inc_due;
  modport timer (input run, input code, input tick, output dec_due, output inc_due);
  modport ctrl (output run, output code, output tick, input dec_due, input inc_due);
endinterface : dffc_timer_if
`default_nettype wire

// ### logic/dffc_interval_timer.sv
// Purpose: per-channel wait between fan start temperature adjustments
// Assumes: tick is one pulse per monitoring cycle
// Notes: decrease wait is half the increase wait
`timescale 1ns/1ps
`default_nettype none
module dffc_interval_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control side
  dffc_timer_if.timer port
);
  import dffc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [10:0] dec_wait;
  logic [10:0] inc_wait;
  logic dec_due_r;
  logic inc_due_r;

  // ==========================================================
  // wait lengths from the code
  assign dec_wait = DEC_BASE << port.code; // [RULE16]
  assign inc_wait = INC_BASE << port.code; // [RULE16]

  // ==========================================================
  // monitoring cycle counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      dec_due_r <= 1'b0;
      inc_due_r <= 1'b0;
    end else if (!port.run) begin
      cnt_r <= '0;
      dec_due_r <= 1'b0;
      inc_due_r <= 1'b0;
    end else if (port.tick) begin
      dec_due_r <= ({1'b0, cnt_r} == dec_wait - 11'h001) ||
                   ({1'b0, cnt_r} == inc_wait - 11'h001); // [RULE2]
      inc_due_r <= ({1'b0, cnt_r} == inc_wait - 11'h001); // [RULE2]
      if ({1'b0, cnt_r} >= inc_wait - 11'h001) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 10'h001;
      end
    end else begin
      dec_due_r <= 1'b0;
      inc_due_r <= 1'b0;
    end
  end

  assign port.dec_due = dec_due_r;
  assign port.inc_due = inc_due_r;

  AST_INC_SPACING: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
      port.inc_due |-> port.dec_due && cnt_r == '0)
    else $error("increase due without decrease due and counter wrap");
endmodule : dffc_interval_timer
`default_nettype wire

// ### logic/dffc_top.sv
// Purpose: dynamic fan floor control registers and supervision
// Assumes: Avalon-MM slave, byte address = register index * 4
// Notes: the adjustment algorithm lives outside; this block paces it
//
// Functional notes
// RULE1: control-1 bit 0 is the MSB of the remote-2 interval code.
// RULE2: each interval code sets monitoring cycles between adjustments.
// RULE3: guard, standby, core below limit set status bit 1; alert if enabled.
// RULE4: during core undervoltage stop hot monitoring, adjustment and shutdown.
// RULE5: core back above limit restores all suspended functions.
// RULE6: remote-1 capture bit plus alarm copies remote-1 temperature.
// RULE7: local capture bit plus alarm copies local temperature.
// RULE8: remote-2 capture bit plus alarm copies remote-2 temperature.
// RULE9: capture bit clear ignores alarm; operating point keeps programmed value.
// RULE10: bit 5 enables remote-1 dynamic start temperature adjustment.
// RULE11: bit 6 enables local dynamic start temperature adjustment.
// RULE12: bit 7 enables remote-2 dynamic start temperature adjustment.
// RULE13: enable clear leaves start temperature unchanged.
// RULE14: lock bit set makes control registers read-only.
// RULE15: three operating-point registers hold per-channel targets.
// RULE16: codes map to decrease waits 4..512, increase waits 8..1024.
// RULE17: control register clears at power-on.
// RULE18: capture once per alarm assertion, on its leading edge.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dffc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [dffc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dffc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dffc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // monitor inputs
  input wire logic [7:0] remote1_temp,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote2_temp,
  input wire logic [7:0] core_supply,
  input wire logic on_standby,
  input wire logic thermal_alarm_pin_n,
  input wire logic monitor_tick,
  // control outputs
  output logic [2:0] dynamic_active,
  output logic [2:0] adjust_dec_due,
  output logic [2:0] adjust_inc_due,
  output logic processor_hot_input_en,
  output logic shutdown_allow,
  output logic irq
);
  import dffc_pkg::*;

  // ==========================================================
  // state
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] oppt_r [NCH];
  logic [7:0] cfg_r;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic [7:0] lim_r;
  logic alarm_prev_r;
  logic [DATA_W-1:0] rdata_r;
  logic wait_r;
  logic irq_r;
  logic [2:0] dyn_r;
  logic [2:0] dec_r;
  logic [2:0] inc_r;
  logic phot_en_r;
  logic shdn_r;

  logic req;
  logic acc;
  logic wr_en;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic [7:0] wbyte;
  logic alarm_edge;
  logic core_low;
  logic locked;
  logic [7:0] temp [NCH];
  logic [2:0] cap_en;
  logic [2:0] dyn_en;
  logic [2:0] code [NCH];
  logic [2:0] tmr_dec;
  logic [2:0] tmr_inc;
  logic [7:0] rd_val;

  // ==========================================================
  // bus decode
  assign req = avs_read | avs_write;
  assign acc = req & !wait_r;
  assign wr_en = acc & avs_write & avs_byteenable[0] & aligned;
  assign idx = avs_address[ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign wbyte = avs_writedata[7:0];
  assign locked = cfg_r[CFG_LOCK];

  // ==========================================================
  // channel views
  assign temp[0] = remote1_temp;
  assign temp[1] = local_temp;
  assign temp[2] = remote2_temp;
  assign cap_en = {ctrl1_r[C1_CAP_R2], ctrl1_r[C1_CAP_LOC], ctrl1_r[C1_CAP_R1]};
  assign dyn_en = {ctrl1_r[C1_DYN_R2], ctrl1_r[C1_DYN_LOC], ctrl1_r[C1_DYN_R1]};
  assign code[0] = ctrl2_r[C2_R1_LSB +: 3];
  assign code[1] = ctrl2_r[C2_LOC_LSB +: 3];
  assign code[2] = {ctrl1_r[C1_R2_MSB], ctrl2_r[C2_R2_LSB +: 2]}; // [RULE1]

  // ==========================================================
  // alarm leading edge and core supervision
  assign alarm_edge = alarm_prev_r & !thermal_alarm_pin_n; // [RULE18]
  assign core_low = ctrl1_r[C1_GUARD] & on_standby & (core_supply < lim_r); // [RULE3]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_prev_r <= 1'b1;
    end else begin
      alarm_prev_r <= thermal_alarm_pin_n;
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle, then the accepting edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (aligned) begin
      case (idx)
        IDX_OPPT_R1: rd_val = oppt_r[0];
        IDX_OPPT_LOC: rd_val = oppt_r[1];
        IDX_OPPT_R2: rd_val = oppt_r[2];
        IDX_CTRL1: rd_val = ctrl1_r;
        IDX_CTRL2: rd_val = ctrl2_r;
        IDX_CFG: rd_val = cfg_r;
        IDX_STAT: rd_val = stat_r;
        IDX_MASK: rd_val = mask_r;
        IDX_CORE_LIM: rd_val = lim_r;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (req && wait_r && avs_read) begin
      rdata_r <= {24'h000000, rd_val};
    end
  end

  // ==========================================================
  // dynamic control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl1_r <= CTRL_RST; // [RULE17]
      ctrl2_r <= CTRL_RST;
    end else if (wr_en && !locked) begin // [RULE14]
      if (idx == IDX_CTRL1) begin
        ctrl1_r <= wbyte;
      end
      if (idx == IDX_CTRL2) begin
        ctrl2_r <= wbyte;
      end
    end
  end

  // ==========================================================
  // lock and limit; lock holds until reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RST;
      lim_r <= LIM_RST;
    end else if (wr_en) begin
      if (idx == IDX_CFG) begin
        cfg_r[CFG_LOCK] <= locked | wbyte[CFG_LOCK];
      end
      if (idx == IDX_CORE_LIM) begin
        lim_r <= wbyte;
      end
    end
  end

  // ==========================================================
  // operating points: capture beats a same-cycle write
  for (genvar c = 0; c < NCH; c++) begin : g_oppt
    logic [IDX_W-1:0] my_idx;
    assign my_idx = IDX_OPPT_R1 + IDX_W'(c);
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        oppt_r[c] <= OPPT_RST; // [RULE15]
      end else if (alarm_edge && cap_en[c]) begin // [RULE6] [RULE7] [RULE8]
        oppt_r[c] <= temp[c];
      end else if (wr_en && !locked && idx == my_idx) begin // [RULE9] [RULE14]
        oppt_r[c] <= wbyte;
      end
    end
  end

  // ==========================================================
  // status (write one to clear, set wins), mask, interrupt
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_r <= STAT_RST;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (wr_en && idx == IDX_STAT && wbyte[b]) begin
          stat_r[b] <= 1'b0;
        end
      end
      if (core_low) begin
        stat_r[ST_CORE_LOW] <= 1'b1; // [RULE3]
      end
      if (alarm_edge && |cap_en) begin
        stat_r[ST_CAPTURE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= MASK_RST;
    end else if (wr_en && idx == IDX_MASK) begin
      mask_r <= wbyte;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r); // [RULE3]
    end
  end

  // ==========================================================
  // interval timers, run only while enabled and not suspended
  for (genvar c = 0; c < NCH; c++) begin : g_tmr
    dffc_timer_if tif ();
    assign tif.run = dyn_en[c] & !core_low; // [RULE10] [RULE11] [RULE12] [RULE4]
    assign tif.code = code[c]; // [RULE2]
    assign tif.tick = monitor_tick;
    assign tmr_dec[c] = tif.dec_due;
    assign tmr_inc[c] = tif.inc_due;
    dffc_interval_timer u_tmr (
      .ref_clk(ref_clk),
      .rst(rst),
      .port(tif.timer)
    );
  end

  // ==========================================================
  // registered control outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dyn_r <= 3'h0;
      dec_r <= 3'h0;
      inc_r <= 3'h0;
      phot_en_r <= 1'b1;
      shdn_r <= 1'b1;
    end else begin
      dyn_r <= core_low ? 3'h0 : dyn_en; // [RULE4] [RULE5] [RULE13]
      dec_r <= core_low ? 3'h0 : (tmr_dec & dyn_en); // [RULE13]
      inc_r <= core_low ? 3'h0 : (tmr_inc & dyn_en); // [RULE13]
      phot_en_r <= !core_low; // [RULE4] [RULE5]
      shdn_r <= !core_low; // [RULE4] [RULE5]
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign dynamic_active = dyn_r;
  assign adjust_dec_due = dec_r;
  assign adjust_inc_due = inc_r;
  assign processor_hot_input_en = phot_en_r;
  assign shutdown_allow = shdn_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_R2_MSB: assert property ((wr_en && !locked && idx == IDX_CTRL1) |=> // [RULE1]
      code[2][2] == $past(wbyte[C1_R2_MSB]))
    else $error("remote-2 interval msb not taken from control 1");
  AST_CORE_STATUS: assert property (core_low |=> stat_r[ST_CORE_LOW]) // [RULE3]
    else $error("core low did not set status");
  AST_CORE_IRQ: assert property ((core_low && mask_r[ST_CORE_LOW] && // [RULE3]
      !(wr_en && idx == IDX_MASK)) |=> ##1 irq)
    else $error("unmasked core low raised no interrupt");
  AST_SUSPEND: assert property (core_low |=> // [RULE4]
      !processor_hot_input_en && !shutdown_allow && dynamic_active == 3'h0 &&
      adjust_dec_due == 3'h0)
    else $error("functions not suspended during core low");
  AST_RESTORE: assert property ((!core_low)[*2] |-> // [RULE5]
      processor_hot_input_en && shutdown_allow)
    else $error("functions not restored after core low");
  AST_CAP_R1: assert property ((alarm_edge && cap_en[0]) |=> // [RULE6]
      oppt_r[0] == $past(remote1_temp))
    else $error("remote-1 temperature not captured");
  AST_CAP_LOC: assert property ((alarm_edge && cap_en[1]) |=> // [RULE7]
      oppt_r[1] == $past(local_temp))
    else $error("local temperature not captured");
  AST_CAP_R2: assert property ((alarm_edge && cap_en[2]) |=> // [RULE8]
      oppt_r[2] == $past(remote2_temp))
    else $error("remote-2 temperature not captured");
  AST_NO_CAP: assert property ((!cap_en[0] && !(wr_en && idx == IDX_OPPT_R1)) |=> // [RULE9]
      $stable(oppt_r[0]))
    else $error("operating point moved without capture or write");
  AST_NO_CAP_R2: assert property ((!cap_en[2] && !(wr_en && idx == IDX_OPPT_R2)) |=> // [RULE9]
      $stable(oppt_r[2]))
    else $error("remote-2 operating point moved without capture or write");
  AST_DYN_OFF: assert property (!dyn_en[1] |=> adjust_dec_due[1] == 1'b0 && // [RULE13]
      adjust_inc_due[1] == 1'b0 && !dynamic_active[1])
    else $error("disabled channel still adjusting");
  AST_LOCK: assert property ((locked && wr_en) |=> $stable(ctrl1_r) && // [RULE14]
      $stable(ctrl2_r))
    else $error("locked control register changed");
  AST_ONCE: assert property ((!thermal_alarm_pin_n && !alarm_prev_r && !wr_en) |=> // [RULE18]
      $stable(oppt_r[0]) && $stable(oppt_r[1]) && $stable(oppt_r[2]))
    else $error("capture repeated while alarm held");

  COV_CAPTURE: cover property (alarm_edge && cap_en[0]);
  COV_CORE_LOW: cover property (core_low ##1 !core_low);
  COV_ADJUST: cover property (adjust_inc_due[0]);
  COV_LOCKED_WRITE: cover property (locked && wr_en && idx == IDX_CTRL1);
  COV_DEC_ONLY: cover property (adjust_dec_due[2] && !adjust_inc_due[2]);
endmodule : dffc_top
`default_nettype wire

// ### verif/dffc_top_bench.sv
// Purpose: self-checking bench of the dynamic fan floor control block
// Assumes: bus answers with one wait state; a register model mirrors the map
// Notes: all inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module dffc_top_bench;
  import dffc_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] temp [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] core_supply = 8'hFF;
  logic on_standby = 1'b0;
  logic thermal_alarm_pin_n = 1'b1;
  logic monitor_tick = 1'b0;
  logic [2:0] dynamic_active;
  logic [2:0] adjust_dec_due;
  logic [2:0] adjust_inc_due;
  logic processor_hot_input_en;
  logic shutdown_allow;
  logic irq;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] mdl [128];
  logic counting = 1'b0;
  int dec_n [3] = '{0, 0, 0};
  int inc_n [3] = '{0, 0, 0};
  int code [3] = '{0, 1, 4};
  logic [31:0] q;
  int w;

  always #50 ref_clk = ~ref_clk;

  dffc_top u_dffc_top (
    .ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .remote1_temp(temp[0]), .local_temp(temp[1]), .remote2_temp(temp[2]),
    .core_supply(core_supply), .on_standby(on_standby),
    .thermal_alarm_pin_n(thermal_alarm_pin_n), .monitor_tick(monitor_tick),
    .dynamic_active(dynamic_active), .adjust_dec_due(adjust_dec_due),
    .adjust_inc_due(adjust_inc_due), .processor_hot_input_en(processor_hot_input_en),
    .shutdown_allow(shutdown_allow), .irq(irq)
  );

  // pulse tally of the pacing outputs
  always @(posedge ref_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (counting && adjust_dec_due[c] === 1'b1) dec_n[c] = dec_n[c] + 1;
      if (counting && adjust_inc_due[c] === 1'b1) inc_n[c] = inc_n[c] + 1;
    end
  end

  // ==========================================================
  // helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus_op(input logic wr_en, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                        input logic [3:0] be, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= ~wr_en;
    avs_write <= wr_en;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("wrong value waitrequest expected 0 seen 1");
      final_report();
    end
  endtask : bus_op

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] rq;
    logic ok;
    bus_op(1'b1, idx, d, be, rq);
    ok = (idx >= IDX_OPPT_R1 && idx <= IDX_CTRL2) || idx == IDX_CFG || idx == IDX_MASK;
    ok = (ok || idx == IDX_CORE_LIM) && be[0];
    if (mdl[IDX_CFG][CFG_LOCK] && idx >= IDX_OPPT_R1 && idx <= IDX_CTRL2) ok = 1'b0;
    if (ok) mdl[idx] = d;
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    logic [31:0] rq;
    bus_op(1'b0, idx, 8'h00, 4'hF, rq);
    chk($sformatf("reg %h", idx), {24'h0, exp}, rq);
  endtask : rd

  task automatic outs(input logic [2:0] dyn, input logic en, input logic ir);
    chk("dynamic_active", dyn, dynamic_active);
    chk("processor_hot_input_en", en, processor_hot_input_en);
    chk("shutdown_allow", en, shutdown_allow);
    chk("irq", ir, irq);
  endtask : outs

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(53289));
    foreach (mdl[i]) mdl[i] = 8'h00;
    for (int c = 0; c < 3; c++) mdl[IDX_OPPT_R1 + c] = OPPT_RST;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    outs(3'b000, 1'b1, 1'b0);
    // reset values and an unmapped place
    rd(IDX_CTRL1, CTRL_RST);
    rd(IDX_CTRL2, CTRL_RST);
    for (int c = 0; c < 3; c++) rd(IDX_W'(IDX_OPPT_R1 + c), OPPT_RST);
    wr(7'h10, 8'hA5, 4'hF);
    rd(7'h10, 8'h00);
    // field storage and enable mapping, random values
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CTRL1, 8'($urandom) & 8'hE1, 4'hF);
      wr(IDX_CTRL2, 8'($urandom), 4'hF);
      rd(IDX_CTRL1, mdl[IDX_CTRL1]);
      rd(IDX_CTRL2, mdl[IDX_CTRL2]);
      outs(mdl[IDX_CTRL1][7:5], 1'b1, 1'b0);
    end
    wr(IDX_CTRL1, 8'hFF, 4'h0);
    rd(IDX_CTRL1, mdl[IDX_CTRL1]);
    // alarm capture for every pattern of capture bits
    for (int p = 0; p < 8; p++) begin
      for (int c = 0; c < 3; c++) wr(IDX_W'(IDX_OPPT_R1 + c), 8'($urandom), 4'hF);
      wr(IDX_CTRL1, 8'(p << 2), 4'hF);
      @(posedge ref_clk);
      for (int c = 0; c < 3; c++) temp[c] <= 8'($urandom);
      thermal_alarm_pin_n <= 1'b0;
      @(posedge ref_clk);
      for (int c = 0; c < 3; c++) if (p[c]) mdl[IDX_OPPT_R1 + c] = temp[c];
      for (int c = 0; c < 3; c++) temp[c] <= ~temp[c];
      repeat (3) @(posedge ref_clk);
      for (int c = 0; c < 3; c++) rd(IDX_W'(IDX_OPPT_R1 + c), mdl[IDX_OPPT_R1 + c]);
      thermal_alarm_pin_n <= 1'b1;
    end
    bus_op(1'b1, IDX_STAT, 8'h03, 4'hF, q);
    rd(IDX_STAT, 8'h00);
    // core undervoltage guard
    wr(IDX_CORE_LIM, 8'h80, 4'hF);
    wr(IDX_MASK, 8'h02, 4'hF);
    wr(IDX_CTRL1, 8'hE0, 4'hF);
    core_supply <= 8'h40;
    on_standby <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(3'b111, 1'b1, 1'b0);
    wr(IDX_CTRL1, 8'hE2, 4'hF);
    repeat (3) @(posedge ref_clk);
    outs(3'b000, 1'b0, 1'b1);
    bus_op(1'b1, IDX_STAT, 8'h02, 4'hF, q);
    rd(IDX_STAT, 8'h02);
    core_supply <= 8'h81;
    repeat (3) @(posedge ref_clk);
    outs(3'b111, 1'b1, 1'b1);
    bus_op(1'b1, IDX_STAT, 8'h02, 4'hF, q);
    rd(IDX_STAT, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("irq", 1'b0, irq);
    // adjustment pacing per channel
    wr(IDX_CTRL2, 8'h08, 4'hF);
    wr(IDX_CTRL1, 8'h00, 4'hF);
    wr(IDX_CTRL1, 8'hE1, 4'hF);
    counting <= 1'b1;
    for (int t = 0; t < 128; t++) begin
      monitor_tick <= 1'b1;
      @(posedge ref_clk);
      monitor_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    counting <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      w = 8 << code[c];
      chk($sformatf("inc pulses %0d", c), 128 / w, inc_n[c]);
      chk($sformatf("dec pulses %0d", c), 2 * (128 / w), dec_n[c]);
    end
    // lock makes the control and operating point places read-only
    wr(IDX_CFG, 8'h01, 4'hF);
    wr(IDX_CTRL1, 8'($urandom), 4'hF);
    wr(IDX_CTRL2, 8'($urandom), 4'hF);
    wr(IDX_OPPT_LOC, 8'($urandom), 4'hF);
    rd(IDX_CTRL1, mdl[IDX_CTRL1]);
    rd(IDX_CTRL2, mdl[IDX_CTRL2]);
    rd(IDX_OPPT_LOC, mdl[IDX_OPPT_LOC]);
    final_report();
  end
endmodule : dffc_top_bench
`default_nettype wire
